// ==== inc/bsfc_pkg.sv ====
package bsfc_pkg;

  // **************************************************************************
  // Address space decode from the two most significant address bits.
  // **************************************************************************
  localparam int         SPACE_MSB     = 31;
  localparam int         SPACE_LSB     = 30;
  localparam logic [1:0] SPACE_SRAM    = 2'h0;
  localparam logic [1:0] SPACE_FAST_IO = 2'h1;
  localparam logic [1:0] SPACE_SLOW_IO = 2'h2;
  localparam logic [1:0] SPACE_FLASH   = 2'h3;

  // **************************************************************************
  // Byte lane decode from the three least significant address bits.
  // **************************************************************************
  localparam int         LANE_MSB      = 2;
  localparam int         LANE_COUNT    = 8;
  localparam logic [2:0] SIZE_EIGHT    = 3'h0;

  // **************************************************************************
  // Claimed transfer type codes.
  // **************************************************************************
  localparam logic [4:0] TT_WRITE_FLUSH = 5'h02;
  localparam logic [4:0] TT_WRITE_KILL  = 5'h06;
  localparam logic [4:0] TT_READ        = 5'h0A;
  localparam logic [4:0] TT_READ_RWITM  = 5'h0E;

  // **************************************************************************
  // Access timing in clocks from the transfer start to the beat acknowledge.
  // **************************************************************************
  localparam logic [3:0] FLASH_ACCESS_CYC   = 4'h6;
  localparam logic [3:0] FAST_IO_ACCESS_CYC = 4'h4;
  localparam logic [3:0] SLOW_IO_ACCESS_CYC = 4'hC;
  localparam logic [3:0] WAIT_STEP          = 4'h1;
  localparam logic [1:0] BURST_LAST_BEAT    = 2'h3;
  localparam logic [1:0] BEAT_FIRST         = 2'h0;
  localparam logic [1:0] BEAT_STEP          = 2'h1;

  // **************************************************************************
  // Reset values.
  // **************************************************************************
  localparam logic [7:0] STROBES_IDLE = 8'hFF;
  localparam logic [3:0] WAIT_RESET   = 4'h0;
  localparam logic [1:0] SPACE_RESET  = 2'h0;

  typedef enum logic [6:0] {
    BSFC_IDLE       = 7'h01,
    BSFC_SRAM_ADDR  = 7'h02,
    BSFC_SRAM_WAIT  = 7'h04,
    BSFC_SRAM_BEAT  = 7'h08,
    BSFC_SRAM_DESEL = 7'h10,
    BSFC_SLOW_WAIT  = 7'h20,
    BSFC_ERR_END    = 7'h40
  } bsfc_state_t;

endpackage : bsfc_pkg

// ==== rtl/bsfc_lane_decode.sv ====
`timescale 1ns/100ps
module bsfc_lane_decode
  import bsfc_pkg::*;
(
  input  wire logic [2:0] lane_addr,
  input  wire logic [2:0] lane_size,
  input  wire logic       lane_burst,
  output logic      [7:0] lane_enable
);

  // **************************************************************************
  // Lane mask.
  // **************************************************************************
  function automatic logic [7:0] lane_mask(input logic [2:0] a, input logic [2:0] sz,
                                           input logic bst);
    logic [3:0] first;
    logic [3:0] count;
    logic [3:0] lane;
    logic [7:0] m;
    first = {1'h0, a};
    count = (sz == SIZE_EIGHT) ? 4'h8 : {1'h0, sz};
    m     = 8'h00;
    for (int i = 0; i < LANE_COUNT; i++) begin
      lane = 4'(i);
      m[i] = bst || ((lane >= first) && (lane < 4'(first + count)));
    end
    return m;
  endfunction : lane_mask

  always_comb begin
    lane_enable = lane_mask(lane_addr, lane_size, lane_burst);
  end

endmodule : bsfc_lane_decode

// ==== rtl/bsfc_ctrl.sv ====
`timescale 1ns/100ps
// Contract
// - Address strobe and chip enable go low together to latch the SRAM address.
// - SRAM chip enable and address strobe assert one clock after transfer start.
// - SRAM writes drive sized byte strobes; reads drive output enable, all lanes.
// - Burst advance low exactly three clocks for burst beats 2-4, else high.
// - No throttling and no wait inserted after the SRAM address strobe.
// - No streaming; every SRAM transfer restarts with a full initial access.
// - After each SRAM access, pulse address strobe with chip enable high.
// - Flash accepts single beats only; bursts to flash are not serviced.
// - One shared flash read enable on reads; flash select on every access.
// - Flash writes are qualified by per-lane byte write strobes.
// - Flash beat acknowledge delayed a fixed count covering read access time.
// - I/O accepts any write size on the selected byte lanes.
// - Each I/O range has its own wait count, fast and slow.
// - I/O writes use the shared byte write strobes, no separate write signal.
// - I/O offers separate read/write strobes and direction-plus-strobe controls.
// - Cycle start from transfer start; classify by type, size and burst flag.
// - Destination chosen by the two most significant address bits.
// - Three low address bits give byte lanes and burst start position; the lane decode ignores them on bursts (all lanes).
// - Address acknowledge on the final beat; beat acknowledge on each beat.
// - Unsupported transfers get error acknowledge instead of beat acknowledge.
// - SRAM address strobe asserts before the first beat of every access.
// - One of two I/O selects on each I/O access; read enable on reads.
// - Bus grant and bus busy lines are not monitored.
// - Map SRAM, fast I/O, slow I/O, flash; timing 3-1-1-1, 4, 12, 6.
// - Claim only flush/kill writes, read and intent-to-modify reads; else error.
module bsfc_ctrl
  import bsfc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        transfer_start_n,
  input  wire logic [4:0]  transfer_type,
  input  wire logic [2:0]  transfer_size,
  input  wire logic        burst_flag_n,
  input  wire logic [31:0] addr,
  output logic             addr_ack_n,
  output logic             beat_ack_n,
  output logic             error_ack_n,
  output logic             sram_select_n,
  output logic             sram_chip_enable_n,
  output logic             sram_addr_strobe_n,
  output logic             sram_read_enable_n,
  output logic             burst_step_n,
  output logic      [7:0]  byte_write_strobe_n,
  output logic             flash_select_n,
  output logic             flash_read_enable_n,
  output logic      [1:0]  io_select_n,
  output logic             io_read_enable_n,
  output logic             io_rd_wr_n,
  output logic             io_strobe_n
);

  // **************************************************************************
  // Start detection and classification.
  // **************************************************************************
  bsfc_state_t state_q;
  bsfc_state_t state_d;
  logic [1:0]  space_q;
  logic        write_q;
  logic        burst_q;
  logic [1:0]  beat_q;
  logic [3:0]  wait_q;
  logic [7:0]  bwe_q;
  logic        io_rd_wr_q;
  logic [7:0]  lanes;
  logic [1:0]  req_space;
  logic        req_burst;
  logic        req_write;
  logic        req_type_ok;
  logic        take;
  logic        take_err;
  logic        take_sram;
  logic        last_beat;
  logic        slow_done;

  assign req_space   = addr[SPACE_MSB:SPACE_LSB];
  assign req_burst   = !burst_flag_n;
  assign req_type_ok = (transfer_type == TT_WRITE_FLUSH) || (transfer_type == TT_WRITE_KILL) ||
                       (transfer_type == TT_READ) || (transfer_type == TT_READ_RWITM);
  assign req_write   = (transfer_type == TT_WRITE_FLUSH) || (transfer_type == TT_WRITE_KILL);
  assign take        = !transfer_start_n && (state_q == BSFC_IDLE);
  assign take_err    = take && (!req_type_ok || (req_burst && (req_space != SPACE_SRAM)));
  assign take_sram   = take && !take_err && (req_space == SPACE_SRAM);
  assign last_beat   = (state_q == BSFC_SRAM_BEAT) && (!burst_q || (beat_q == BURST_LAST_BEAT));
  assign slow_done   = (state_q == BSFC_SLOW_WAIT) && (wait_q == WAIT_RESET);

  bsfc_lane_decode u_bsfc_lane_decode (
    .lane_addr   (addr[LANE_MSB:0]),
    .lane_size   (transfer_size),
    .lane_burst  (req_burst),
    .lane_enable (lanes)
  );

  // **************************************************************************
  // Bus state machine.
  // **************************************************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      BSFC_IDLE: begin
        if (take_err) begin
          state_d = BSFC_ERR_END;
        end else if (take_sram) begin
          state_d = BSFC_SRAM_ADDR;
        end else if (take) begin
          state_d = BSFC_SLOW_WAIT;
        end
      end
      BSFC_SRAM_ADDR: begin
        state_d = BSFC_SRAM_WAIT;
      end
      BSFC_SRAM_WAIT: begin
        state_d = BSFC_SRAM_BEAT;
      end
      BSFC_SRAM_BEAT: begin
        if (last_beat) begin
          state_d = BSFC_SRAM_DESEL;
        end
      end
      BSFC_SRAM_DESEL: begin
        state_d = BSFC_IDLE;
      end
      BSFC_SLOW_WAIT: begin
        if (slow_done) begin
          state_d = BSFC_IDLE;
        end
      end
      BSFC_ERR_END: begin
        state_d = BSFC_IDLE;
      end
      default: begin
        state_d = BSFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= BSFC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // **************************************************************************
  // Transfer attributes held for the whole access.
  // **************************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      space_q    <= SPACE_RESET;
      write_q    <= 1'h0;
      burst_q    <= 1'h0;
      io_rd_wr_q <= 1'h1;
    end else if (take) begin
      space_q    <= req_space;
      write_q    <= req_write;
      burst_q    <= req_burst;
      io_rd_wr_q <= !req_write;
    end
  end

  // **************************************************************************
  // Beat counter and per-space wait counter.
  // **************************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      beat_q <= BEAT_FIRST;
    end else if (state_q != BSFC_SRAM_BEAT) begin
      beat_q <= BEAT_FIRST;
    end else if (!last_beat) begin
      beat_q <= beat_q + BEAT_STEP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wait_q <= WAIT_RESET;
    end else if (take) begin
      unique case (req_space)
        SPACE_FLASH: begin
          wait_q <= FLASH_ACCESS_CYC - WAIT_STEP;
        end
        SPACE_FAST_IO: begin
          wait_q <= FAST_IO_ACCESS_CYC - WAIT_STEP;
        end
        SPACE_SLOW_IO: begin
          wait_q <= SLOW_IO_ACCESS_CYC - WAIT_STEP;
        end
        SPACE_SRAM: begin
          wait_q <= WAIT_RESET;
        end
      endcase
    end else if ((state_q == BSFC_SLOW_WAIT) && !slow_done) begin
      wait_q <= wait_q - WAIT_STEP;
    end
  end

  // **************************************************************************
  // Shared byte write strobes.
  // **************************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bwe_q <= STROBES_IDLE;
    end else if (take && !take_err && req_write) begin
      bwe_q <= ~lanes;
    end else if ((state_d == BSFC_IDLE) || (state_d == BSFC_SRAM_DESEL)) begin
      bwe_q <= STROBES_IDLE;
    end
  end

  // **************************************************************************
  // Pin controls.
  // **************************************************************************
  logic sram_active;
  logic flash_active;
  logic io_active;

  assign sram_active  = (state_q == BSFC_SRAM_ADDR) || (state_q == BSFC_SRAM_WAIT) ||
                        (state_q == BSFC_SRAM_BEAT);
  assign flash_active = (state_q == BSFC_SLOW_WAIT) && (space_q == SPACE_FLASH);
  assign io_active    = (state_q == BSFC_SLOW_WAIT) && (space_q != SPACE_FLASH);

  assign sram_select_n       = srst || !sram_active;
  assign sram_chip_enable_n  = srst || !sram_active;
  assign sram_addr_strobe_n  = srst || !((state_q == BSFC_SRAM_ADDR) ||
                                         (state_q == BSFC_SRAM_DESEL));
  assign sram_read_enable_n  = srst || !(sram_active && !write_q);
  assign burst_step_n        = srst || !((state_q == BSFC_SRAM_BEAT) && burst_q &&
                                         (beat_q != BEAT_FIRST));
  assign byte_write_strobe_n = srst ? STROBES_IDLE : bwe_q;
  assign flash_select_n      = srst || !flash_active;
  assign flash_read_enable_n = srst || !(flash_active && !write_q);
  assign io_select_n[0]      = srst || !(io_active && (space_q == SPACE_FAST_IO));
  assign io_select_n[1]      = srst || !(io_active && (space_q == SPACE_SLOW_IO));
  assign io_read_enable_n    = srst || !(io_active && !write_q);
  assign io_strobe_n         = srst || !io_active;
  assign io_rd_wr_n          = srst || io_rd_wr_q;

  // **************************************************************************
  // Acknowledges.
  // **************************************************************************
  assign beat_ack_n  = srst || !((state_q == BSFC_SRAM_BEAT) || slow_done);
  assign addr_ack_n  = srst || !(last_beat || slow_done || (state_q == BSFC_ERR_END));
  assign error_ack_n = srst || (state_q != BSFC_ERR_END);

  // **************************************************************************
  // Checks.
  // **************************************************************************
  property p_sram_latch;
    @(posedge sys_clk) disable iff (srst)
    $fell(sram_chip_enable_n) |-> $fell(sram_addr_strobe_n);
  endproperty
  a_sram_latch: assert property (p_sram_latch) else $error("chip enable without strobe");

  property p_sram_start;
    @(posedge sys_clk) disable iff (srst)
    take_sram |=> !sram_chip_enable_n && !sram_addr_strobe_n ##1 sram_addr_strobe_n;
  endproperty
  a_sram_start: assert property (p_sram_start) else $error("sram start not one clock late");

  property p_read_no_strobe;
    @(posedge sys_clk) disable iff (srst)
    !sram_read_enable_n |-> (byte_write_strobe_n == STROBES_IDLE);
  endproperty
  a_read_no_strobe: assert property (p_read_no_strobe) else $error("strobe on read");

  property p_burst_step;
    @(posedge sys_clk) disable iff (srst)
    take_sram && req_burst |=> burst_step_n[*3] ##1 (!burst_step_n)[*3] ##1 burst_step_n;
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst advance length wrong");

  property p_sram_first_beat;
    @(posedge sys_clk) disable iff (srst)
    take_sram |=> beat_ack_n[*2] ##1 !beat_ack_n;
  endproperty
  a_sram_first_beat: assert property (p_sram_first_beat) else $error("sram lead wrong");

  property p_deselect;
    @(posedge sys_clk) disable iff (srst)
    !addr_ack_n && !sram_select_n |=> !sram_addr_strobe_n && sram_chip_enable_n;
  endproperty
  a_deselect: assert property (p_deselect) else $error("no deselect cycle");

  property p_flash_burst;
    @(posedge sys_clk) disable iff (srst)
    take && req_type_ok && req_burst && (req_space == SPACE_FLASH) |=>
      !error_ack_n && flash_select_n;
  endproperty
  a_flash_burst: assert property (p_flash_burst) else $error("flash burst serviced");

  property p_flash_wait;
    @(posedge sys_clk) disable iff (srst)
    take && !take_err && (req_space == SPACE_FLASH) |=>
      (beat_ack_n && !flash_select_n)[*5] ##1 !beat_ack_n;
  endproperty
  a_flash_wait: assert property (p_flash_wait) else $error("flash wait wrong");

  property p_slow_io_wait;
    @(posedge sys_clk) disable iff (srst)
    take && !take_err && (req_space == SPACE_SLOW_IO) |=>
      beat_ack_n[*8] ##1 beat_ack_n[*3] ##1 (!beat_ack_n && !io_select_n[1]);
  endproperty
  a_slow_io_wait: assert property (p_slow_io_wait) else $error("slow io wait wrong");

  property p_error_end;
    @(posedge sys_clk) disable iff (srst)
    take && !req_type_ok |=> !error_ack_n && beat_ack_n && !addr_ack_n ##1 error_ack_n;
  endproperty
  a_error_end: assert property (p_error_end) else $error("bad type not errored");

  property p_addr_ack_beat;
    @(posedge sys_clk) disable iff (srst)
    !addr_ack_n |-> (beat_ack_n != error_ack_n);
  endproperty
  a_addr_ack_beat: assert property (p_addr_ack_beat) else $error("address ack alone");

  property p_reset_idle;
    @(posedge sys_clk)
    srst |-> addr_ack_n && beat_ack_n && error_ack_n && sram_select_n && flash_select_n &&
             (io_select_n == 2'h3) && (byte_write_strobe_n == STROBES_IDLE);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs active in reset");

  property p_flash_read;
    @(posedge sys_clk) disable iff (srst)
    !flash_read_enable_n |-> !flash_select_n && (byte_write_strobe_n == STROBES_IDLE);
  endproperty
  a_flash_read: assert property (p_flash_read) else $error("flash read enable misplaced");

  property p_io_select;
    @(posedge sys_clk) disable iff (srst)
    !io_strobe_n |-> $onehot(~io_select_n) && (io_read_enable_n == !io_rd_wr_n);
  endproperty
  a_io_select: assert property (p_io_select) else $error("io select or direction wrong");

  property p_no_stream;
    @(posedge sys_clk) disable iff (srst)
    !sram_addr_strobe_n && sram_chip_enable_n |=> sram_chip_enable_n && sram_addr_strobe_n;
  endproperty
  a_no_stream: assert property (p_no_stream) else $error("sram access streamed");

  property p_fast_io_wait;
    @(posedge sys_clk) disable iff (srst)
    take && !take_err && (req_space == SPACE_FAST_IO) |=>
      (beat_ack_n && !io_select_n[0])[*3] ##1 (!beat_ack_n && !addr_ack_n);
  endproperty
  a_fast_io_wait: assert property (p_fast_io_wait) else $error("fast io wait wrong");

endmodule : bsfc_ctrl

// ==== sim/bsfc_master_model.sv ====
`timescale 1ns/100ps
// ****************************************************************************
// Single bus master that starts one transfer at a time.
// ****************************************************************************
module bsfc_master_model
(
  input  wire logic        sys_clk,
  input  wire logic        addr_ack_n,
  output logic             transfer_start_n,
  output logic      [4:0]  transfer_type,
  output logic      [2:0]  transfer_size,
  output logic             burst_flag_n,
  output logic      [31:0] addr
);

  initial begin
    transfer_start_n = 1'b1;
    transfer_type    = 5'h00;
    transfer_size    = 3'h0;
    burst_flag_n     = 1'b1;
    addr             = 32'h0000_0000;
  end

  // Start strobe lasts one clock; the fields are held until the address acknowledge.
  task automatic start(input logic [4:0] tt, input logic [2:0] sz, input logic bn,
                       input logic [31:0] a);
    transfer_start_n = 1'b0;
    transfer_type    = tt;
    transfer_size    = sz;
    burst_flag_n     = bn;
    addr             = a;
    @(posedge sys_clk);
    #1;
    transfer_start_n = 1'b1;
  endtask : start

  task automatic set_start(input logic v);
    transfer_start_n = v;
  endtask : set_start

  // After the address acknowledge the fields no longer hold their last value.
  always begin
    @(posedge sys_clk);
    if (addr_ack_n === 1'b0) begin
      #1;
      addr          = ~addr;
      transfer_type = ~transfer_type;
      transfer_size = ~transfer_size;
      burst_flag_n  = ~burst_flag_n;
    end
  end

endmodule : bsfc_master_model

// ==== sim/bsfc_ctrl_tb.sv ====
`timescale 1ns/100ps
module bsfc_ctrl_tb
  import bsfc_pkg::*;
;

  logic        sys_clk;
  logic        srst;
  logic        transfer_start_n;
  logic [4:0]  transfer_type;
  logic [2:0]  transfer_size;
  logic        burst_flag_n;
  logic [31:0] addr;
  logic        addr_ack_n;
  logic        beat_ack_n;
  logic        error_ack_n;
  logic        sram_select_n;
  logic        sram_chip_enable_n;
  logic        sram_addr_strobe_n;
  logic        sram_read_enable_n;
  logic        burst_step_n;
  logic [7:0]  byte_write_strobe_n;
  logic        flash_select_n;
  logic        flash_read_enable_n;
  logic [1:0]  io_select_n;
  logic        io_read_enable_n;
  logic        io_rd_wr_n;
  logic        io_strobe_n;
  logic [13:0] obs;
  int          fails;
  int          tests_run;

  assign obs = {addr_ack_n, beat_ack_n, error_ack_n, sram_select_n, sram_chip_enable_n,
                sram_addr_strobe_n, sram_read_enable_n, burst_step_n, flash_select_n,
                flash_read_enable_n, io_select_n, io_read_enable_n, io_strobe_n};

  bsfc_ctrl u_bsfc_ctrl (
    .sys_clk             (sys_clk),
    .srst                (srst),
    .transfer_start_n    (transfer_start_n),
    .transfer_type       (transfer_type),
    .transfer_size       (transfer_size),
    .burst_flag_n        (burst_flag_n),
    .addr                (addr),
    .addr_ack_n          (addr_ack_n),
    .beat_ack_n          (beat_ack_n),
    .error_ack_n         (error_ack_n),
    .sram_select_n       (sram_select_n),
    .sram_chip_enable_n  (sram_chip_enable_n),
    .sram_addr_strobe_n  (sram_addr_strobe_n),
    .sram_read_enable_n  (sram_read_enable_n),
    .burst_step_n        (burst_step_n),
    .byte_write_strobe_n (byte_write_strobe_n),
    .flash_select_n      (flash_select_n),
    .flash_read_enable_n (flash_read_enable_n),
    .io_select_n         (io_select_n),
    .io_read_enable_n    (io_read_enable_n),
    .io_rd_wr_n          (io_rd_wr_n),
    .io_strobe_n         (io_strobe_n)
  );

  bsfc_master_model u_bsfc_master_model (
    .sys_clk          (sys_clk),
    .addr_ack_n       (addr_ack_n),
    .transfer_start_n (transfer_start_n),
    .transfer_type    (transfer_type),
    .transfer_size    (transfer_size),
    .burst_flag_n     (burst_flag_n),
    .addr             (addr)
  );

  // ****************************************************************************
  // Checking and closing.
  // ****************************************************************************
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // One transfer, checked cycle by cycle until the controller is idle again.
  task automatic xfer(input logic [4:0] tt, input logic [2:0] sz, input logic bn,
                      input logic [31:0] a, input int poke);
    logic        wr;
    logic        err;
    logic [1:0]  sp;
    logic [13:0] e;
    logic [7:0]  eb;
    logic [7:0]  ln;
    int          len;
    int          n;
    wr  = (tt == TT_WRITE_FLUSH) || (tt == TT_WRITE_KILL);
    sp  = a[31:30];
    err = !(wr || tt == TT_READ || tt == TT_READ_RWITM) || (!bn && sp != SPACE_SRAM);
    n   = (sz == SIZE_EIGHT) ? 8 : int'(sz);
    for (int i = 0; i < 8; i++) begin
      ln[i] = !bn || (i >= int'(a[2:0]) && i < int'(a[2:0]) + n);
    end
    len = err ? 1 : (sp == SPACE_SRAM) ? (bn ? 3 : 6) : (sp == SPACE_FLASH) ? 6 :
          (sp == SPACE_FAST_IO) ? 4 : 12;
    u_bsfc_master_model.start(tt, sz, bn, a);
    for (int k = 1; k <= len + 1; k++) begin
      e  = 14'h3FFF;
      eb = 8'hFF;
      if (err) begin
        e[13] = (k != 1);
        e[11] = (k != 1);
      end else if (k <= len) begin
        e[13] = (k != len);
        case (sp)
          SPACE_SRAM: begin
            e[10] = 1'b0;
            e[9]  = 1'b0;
            e[8]  = (k != 1);
            e[7]  = wr;
            e[12] = (k < 3);
            e[6]  = (k < 4);
          end
          SPACE_FLASH: begin
            e[5]  = 1'b0;
            e[4]  = wr;
            e[12] = (k != len);
          end
          default: begin
            e[3]  = (sp != SPACE_SLOW_IO);
            e[2]  = (sp != SPACE_FAST_IO);
            e[1]  = wr;
            e[0]  = 1'b0;
            e[12] = (k != len);
            check({21'h0, io_rd_wr_n}, {21'h0, !wr});
          end
        endcase
        if (wr) begin
          eb = ~ln;
        end
      end else if (sp == SPACE_SRAM) begin
        e[8] = 1'b0;
      end
      check({19'h0, obs[13:11]}, {19'h0, e[13:11]});
      check({17'h0, obs[10:6]}, {17'h0, e[10:6]});
      check({16'h0, obs[5:0]}, {16'h0, e[5:0]});
      check({14'h0, byte_write_strobe_n}, {14'h0, eb});
      if (k == poke) begin
        u_bsfc_master_model.set_start(1'b0);
      end
      if (k == poke + 1) begin
        u_bsfc_master_model.set_start(1'b1);
      end
      @(posedge sys_clk);
      #1;
    end
    if (poke == len + 1) begin
      u_bsfc_master_model.set_start(1'b1);
      @(posedge sys_clk);
      #1;
    end
  endtask : xfer

  // ****************************************************************************
  // Scenarios.
  // ****************************************************************************
  task automatic t_sram();
    xfer(TT_READ, 3'h0, 1'b1, 32'h0000_0010, 0);
    xfer(TT_WRITE_FLUSH, 3'h2, 1'b1, 32'h0000_0026, 0);
    xfer(TT_WRITE_FLUSH, 3'h4, 1'b1, 32'h0000_0006, 0);
    xfer(TT_READ_RWITM, 3'h0, 1'b0, 32'h0000_0100, 7);
    xfer(TT_WRITE_KILL, 3'h0, 1'b0, 32'h3FFF_FFE0, 0);
    $display("Test sram done");
  endtask : t_sram

  task automatic t_flash();
    xfer(TT_READ, 3'h0, 1'b1, 32'hC000_0000, 3);
    xfer(TT_WRITE_FLUSH, 3'h2, 1'b1, 32'hC000_0002, 0);
    xfer(TT_WRITE_KILL, 3'h1, 1'b1, 32'hFFFF_FFF7, 0);
    xfer(TT_READ, 3'h0, 1'b0, 32'hC000_0000, 0);
    $display("Test flash done");
  endtask : t_flash

  task automatic t_io();
    xfer(TT_WRITE_FLUSH, 3'h1, 1'b1, 32'h4000_0003, 0);
    xfer(TT_READ, 3'h1, 1'b1, 32'h7FFF_FFF5, 0);
    xfer(TT_WRITE_KILL, 3'h4, 1'b1, 32'h8000_0004, 0);
    xfer(TT_READ_RWITM, 3'h2, 1'b1, 32'hBFFF_FFFE, 0);
    xfer(TT_WRITE_FLUSH, 3'h0, 1'b0, 32'h8000_0000, 0);
    $display("Test io done");
  endtask : t_io

  task automatic t_types();
    logic [4:0] code;
    for (int c = 0; c < 32; c++) begin
      code = 5'(c);
      if (code != TT_WRITE_FLUSH && code != TT_WRITE_KILL && code != TT_READ &&
          code != TT_READ_RWITM) begin
        xfer(code, 3'h0, 1'b1, 32'h0000_0008, 0);
      end
    end
    $display("Test types done");
  endtask : t_types

  task automatic t_reset();
    u_bsfc_master_model.start(TT_WRITE_KILL, 3'h0, 1'b0, 32'h0000_0040);
    @(posedge sys_clk);
    #1;
    srst = 1'b1;
    #1;
    check({obs, byte_write_strobe_n}, 22'h3F_FFFF);
    @(posedge sys_clk);
    #1;
    srst = 1'b0;
    @(posedge sys_clk);
    #1;
    check({obs, byte_write_strobe_n}, 22'h3F_FFFF);
    xfer(TT_READ, 3'h0, 1'b1, 32'h0000_0000, 0);
    $display("Test reset done");
  endtask : t_reset

  // ****************************************************************************
  // Clock, reset, watchdog and main sequence.
  // ****************************************************************************
  initial begin
    sys_clk = 1'b0;
    forever begin
      #2 sys_clk = ~sys_clk;
    end
  end

  initial begin
    #40000;
    fails++;
    results();
  end

  initial begin
    fails     = 0;
    tests_run = 0;
    srst      = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    t_sram();
    t_flash();
    t_io();
    t_types();
    t_reset();
    results();
  end

endmodule : bsfc_ctrl_tb
